// ==== inc/capture_timer_pkg.sv ====
`default_nettype none
package capture_timer_pkg;
	// Counter width and reset value
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// Channel count
	localparam int NUM_CH = 3;
	// Radio event vector width
	localparam int RF_W = 8;
	// Divider widths
	localparam int DIV_W = 7;
	localparam logic [6:0] DIV_RST = 7'h00;
	// Prescaler codes
	localparam logic [1:0] PRE_DIV1 = 2'h0;
	localparam logic [1:0] PRE_DIV8 = 2'h1;
	localparam logic [1:0] PRE_DIV32 = 2'h2;
	localparam logic [1:0] PRE_DIV128 = 2'h3;
	// Prescaler widths in bits (divide by two to the power)
	localparam logic [2:0] PRE_BITS1 = 3'h0;
	localparam logic [2:0] PRE_BITS8 = 3'h3;
	localparam logic [2:0] PRE_BITS32 = 3'h5;
	localparam logic [2:0] PRE_BITS128 = 3'h7;
	// Counting modes
	localparam logic [1:0] MODE_HALT = 2'h0;
	localparam logic [1:0] MODE_FREE = 2'h1;
	localparam logic [1:0] MODE_MOD = 2'h2;
	localparam logic [1:0] MODE_UPDN = 2'h3;
	// Capture edge codes
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_ANY = 2'h3;
	// Direction state of the up/down counter
	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} dir_e;
	// Per-channel configuration
	typedef struct packed {
		logic [1:0] edge_sel;
		logic channel_mask;
		logic capture_source_select;
	} chan_cfg_s;
	// Per-channel capture value
	typedef logic [15:0] cnt_t;
endpackage : capture_timer_pkg
`default_nettype wire

// ==== hdl/sixteen_bit_capture_timer.sv ====
`default_nettype none
// Summary of operation
// [RULE1] Prescale tick by 1, 8, 32 or 128
// [RULE2] Tick from tick_speed_select, clock untouched
// [RULE3] Low byte read latches high byte
// [RULE4] Any low byte write clears counter
// [RULE5] Nonzero mode runs, zero mode holds
// [RULE6] Free mode wraps 0xFFFF to 0x0000
// [RULE7] Free mode flags overflow at 0xFFFF
// [RULE8] Modulo wraps after terminal value, flags
// [RULE9] Up/down bounces between zero and terminal
// [RULE10] Up/down flags overflow at zero
// [RULE11] Overflow mask gates flag and irq
// [RULE12] Three capture channels, one pin each
// [RULE13] Configured edge copies counter when running
// [RULE14] Pins synchronised; pulses exceed one clock
// [RULE15] Capture sets that channel's flag
// [RULE16] Channel mask gates flag and irq
// [RULE17] Source select picks masked radio events
// [RULE18] Radio capture needs speed selects 000; the code captures radio events at any speed select
// [RULE19] DMA trigger pulse per channel capture
// [RULE20] Flags set regardless of masks
// [RULE21] Reset gives zero count, halted
module sixteen_bit_capture_timer
	import capture_timer_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic [2:0] tick_speed_select,
	input wire logic [1:0] prescale_select,
	input wire logic [1:0] count_mode_field,
	input wire logic [15:0] terminal_count_value,
	input wire logic overflow_mask,
	input wire logic timer_irq_enable,
	input wire chan_cfg_s [NUM_CH-1:0] channel_control,
	input wire logic [RF_W-1:0] radio_event,
	input wire logic [RF_W-1:0] radio_event_mask,
	input wire logic count_low_rd,
	input wire logic count_low_wr,
	input wire logic overflow_flag_clr,
	input wire logic [NUM_CH-1:0] channel_flag_clr,
	input wire logic [NUM_CH-1:0] capture_pin,
	output logic [7:0] count_low_byte,
	output logic [7:0] count_high_byte,
	output logic overflow_flag,
	output logic [NUM_CH-1:0] channel_flag,
	output logic cpu_timer_flag,
	output logic timer_irq,
	output cnt_t [NUM_CH-1:0] channel_capture_value,
	output logic [NUM_CH-1:0] channel_dma_trigger
);

	// ********************************
	// Helpers
	// ********************************

	// Mask of n low ones, used for both dividers
	function automatic logic [6:0] low_ones(input logic [2:0] n);
		logic [7:0] t;
		t = (8'h01 << n) - 8'h01;
		return t[6:0];
	endfunction : low_ones

	// ********************************
	// Declarations
	// ********************************

	logic [6:0] tick_div_r; // Tick divider
	logic [6:0] pre_div_r; // Prescaler
	logic [6:0] tick_lim; // Tick divider wrap mask
	logic [6:0] pre_lim; // Prescaler wrap mask
	logic tick_en; // One timer tick
	logic step_en; // One active counter edge
	logic [15:0] count_r; // Counter
	logic [15:0] count_nxt;
	dir_e dir_r; // Up/down direction
	dir_e dir_nxt;
	logic ovf_evt; // Overflow this cycle
	logic running; // Counter runs
	logic [NUM_CH-1:0] sync1_r; // First sync stage
	logic [NUM_CH-1:0] sync2_r; // Second sync stage
	logic [NUM_CH-1:0] prev_r; // Edge history
	logic [NUM_CH-1:0] cap_evt; // Capture this cycle
	logic radio_hit; // Any enabled radio event
	logic ovf_nxt;
	logic [NUM_CH-1:0] chf_nxt;
	logic cpu_nxt;

	// ********************************
	// Tick and prescaler
	// ********************************

	// Tick runs at clock over two to the select; clock itself untouched
	always_comb begin
		tick_lim = low_ones(tick_speed_select); // RULE2
		tick_en = (tick_div_r & tick_lim) == tick_lim; // RULE2
	end

	// Prescale select to divide width
	always_comb begin
		case (prescale_select)
			PRE_DIV1: pre_lim = low_ones(PRE_BITS1);
			PRE_DIV8: pre_lim = low_ones(PRE_BITS8);
			PRE_DIV32: pre_lim = low_ones(PRE_BITS32);
			default: pre_lim = low_ones(PRE_BITS128);
		endcase
	end

	// Active edge when the prescaler wraps on a tick
	// A low byte write in the same cycle suppresses the step and its overflow
	assign step_en = tick_en && (pre_div_r == pre_lim) && running && !count_low_wr; // RULE1
	assign running = count_mode_field != MODE_HALT; // RULE5

	// Tick divider free-runs so the rate never depends on the mode
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick_div_r <= DIV_RST;
		end else if (clk_en) begin
			tick_div_r <= tick_div_r + 7'h01;
		end
	end

	// Prescaler counts ticks; restarts with the counter
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pre_div_r <= DIV_RST;
		end else if (clk_en) begin
			if (count_low_wr || !running) begin
				pre_div_r <= DIV_RST;
			end else if (tick_en) begin
				if (pre_div_r >= pre_lim) begin
					pre_div_r <= DIV_RST; // RULE1
				end else begin
					pre_div_r <= pre_div_r + 7'h01;
				end
			end
		end
	end

	// ********************************
	// Counter
	// ********************************

	// Next count and overflow per mode
	always_comb begin
		count_nxt = count_r;
		dir_nxt = dir_r;
		ovf_evt = 1'b0;
		case (count_mode_field)
			MODE_FREE: begin
				count_nxt = count_r + 16'h0001; // RULE6
				ovf_evt = count_nxt == CNT_MAX; // RULE7
			end
			MODE_MOD: begin
				// Above terminal also wraps, so a lowered terminal cannot run away
				if (count_r >= terminal_count_value) begin
					count_nxt = CNT_RST; // RULE8
				end else begin
					count_nxt = count_r + 16'h0001;
				end
				ovf_evt = count_nxt == terminal_count_value; // RULE8
			end
			MODE_UPDN: begin
				if (dir_r == DIR_DOWN) begin
					count_nxt = count_r - 16'h0001; // RULE9
				end else if (count_r >= terminal_count_value && count_r != CNT_RST) begin
					count_nxt = count_r - 16'h0001; // RULE9
					dir_nxt = DIR_DOWN;
				end else if (terminal_count_value != CNT_RST) begin
					count_nxt = count_r + 16'h0001;
				end
				// Overflow at the zero turnaround, not at the terminal one
				if (dir_nxt == DIR_DOWN && count_nxt == CNT_RST) begin
					dir_nxt = DIR_UP;
					ovf_evt = 1'b1; // RULE10
				end
			end
			default: count_nxt = count_r; // RULE5
		endcase
	end

	// Counter register; write to low byte wins over counting
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_r <= CNT_RST; // RULE21
			dir_r <= DIR_UP;
		end else if (clk_en) begin
			if (count_low_wr) begin
				count_r <= CNT_RST; // RULE4
				dir_r <= DIR_UP;
			end else if (step_en) begin
				count_r <= count_nxt;
				dir_r <= dir_nxt;
			end
		end
	end

	assign count_low_byte = count_r[7:0];

	// High byte snapshot so a later read pairs with the low byte
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_high_byte <= 8'h00;
		end else if (clk_en && count_low_rd) begin
			count_high_byte <= count_r[15:8]; // RULE3
		end
	end

	// ********************************
	// Capture channels
	// ********************************

	// Two-stage synchroniser plus edge history
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
		end else if (clk_en) begin
			sync1_r <= capture_pin; // RULE14
			sync2_r <= sync1_r; // RULE14
			prev_r <= sync2_r;
		end
	end

	// Radio events are already in this clock domain
	assign radio_hit = |(radio_event & radio_event_mask);

	// Trigger per channel, pin edge or radio
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (channel_control[i].capture_source_select) begin
				cap_evt[i] = radio_hit && running; // RULE17
			end else begin
				case (channel_control[i].edge_sel)
					EDGE_RISE: cap_evt[i] = sync2_r[i] && !prev_r[i]; // RULE13
					EDGE_FALL: cap_evt[i] = !sync2_r[i] && prev_r[i];
					EDGE_ANY: cap_evt[i] = sync2_r[i] ^ prev_r[i];
					default: cap_evt[i] = 1'b0;
				endcase
				cap_evt[i] = cap_evt[i] && running; // RULE13
			end
		end
	end

	// Capture registers, one per channel
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			channel_capture_value <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (cap_evt[i]) begin
					channel_capture_value[i] <= count_r; // RULE12
				end
			end
		end
	end

	// DMA request, one cycle per capture
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			channel_dma_trigger <= '0;
		end else if (clk_en) begin
			channel_dma_trigger <= cap_evt; // RULE19
		end
	end

	// ********************************
	// Flags and interrupt
	// ********************************

	// Set beats clear so no event is lost; masks gate only the cpu flag and irq
	always_comb begin
		ovf_nxt = (overflow_flag && !overflow_flag_clr) || (step_en && ovf_evt); // RULE20
		chf_nxt = (channel_flag & ~channel_flag_clr) | cap_evt; // RULE15
		cpu_nxt = (ovf_nxt && overflow_mask); // RULE11
		for (int i = 0; i < NUM_CH; i++) begin
			cpu_nxt = cpu_nxt || (chf_nxt[i] && channel_control[i].channel_mask); // RULE16
		end
	end

	// Flag registers; enabling a mask on a set flag raises the request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			overflow_flag <= 1'b0;
			channel_flag <= '0;
			cpu_timer_flag <= 1'b0;
			timer_irq <= 1'b0;
		end else if (clk_en) begin
			overflow_flag <= ovf_nxt;
			channel_flag <= chf_nxt;
			cpu_timer_flag <= cpu_nxt; // RULE11
			timer_irq <= cpu_nxt && timer_irq_enable; // RULE16
		end
	end

	// ********************************
	// Checks
	// ********************************

	free_wrap_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
		clk_en && !count_low_wr && step_en && count_mode_field == MODE_FREE
		&& count_r == CNT_MAX |=> count_r == CNT_RST)
		else $error("free mode did not wrap to zero");
	free_ovf_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
		clk_en && step_en && count_mode_field == MODE_FREE
		&& count_r == 16'hFFFE |=> overflow_flag)
		else $error("free mode overflow flag missing");
	mod_wrap_a: assert property (@(posedge clk) disable iff (!nrst) // RULE8
		clk_en && !count_low_wr && step_en && count_mode_field == MODE_MOD
		&& count_r == terminal_count_value |=> count_r == CNT_RST)
		else $error("modulo mode did not wrap");
	halt_hold_a: assert property (@(posedge clk) disable iff (!nrst) // RULE5
		clk_en && !count_low_wr && count_mode_field == MODE_HALT |=> $stable(count_r))
		else $error("halted counter moved");
	low_write_a: assert property (@(posedge clk) disable iff (!nrst) // RULE4
		clk_en && count_low_wr |=> count_r == CNT_RST)
		else $error("low byte write did not clear");
	high_latch_a: assert property (@(posedge clk) disable iff (!nrst) // RULE3
		clk_en && count_low_rd |=> count_high_byte == $past(count_r[15:8]))
		else $error("high byte not latched");
	capture_copy_a: assert property (@(posedge clk) disable iff (!nrst) // RULE13
		clk_en && cap_evt[0] |=> channel_capture_value[0] == $past(count_r)
		&& channel_flag[0] && channel_dma_trigger[0])
		else $error("capture did not copy counter");
	updn_ovf_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
		clk_en && step_en && count_mode_field == MODE_UPDN && dir_r == DIR_DOWN
		&& count_r == 16'h0001 |=> overflow_flag && dir_r == DIR_UP)
		else $error("up/down zero turnaround missed");
	freeze_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		!clk_en |=> $stable(count_r) && $stable(overflow_flag) && $stable(channel_flag))
		else $error("state moved while clock enable low");
	irq_gate_a: assert property (@(posedge clk) disable iff (!nrst) // RULE11
		$rose(timer_irq) |-> $past(timer_irq_enable) && cpu_timer_flag)
		else $error("irq without enable");

endmodule : sixteen_bit_capture_timer
`default_nettype wire

// ==== bench/event_source.sv ====
`default_nettype none
// ****************
// Far-side events
// ****************
module event_source
	import capture_timer_pkg::*;
(
	input wire logic [NUM_CH-1:0] pin_want,
	input wire logic [RF_W-1:0] rf_want,
	output logic [NUM_CH-1:0] capture_pin,
	output logic [RF_W-1:0] radio_event
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quiet lines first; then pins and radio strobes follow requests 1 ns later,
	// clear of the sampling edge; pin levels are held for cycles
	initial begin
		capture_pin = '0;
		radio_event = '0;
		forever begin
			@(pin_want or rf_want);
			capture_pin <= #1 pin_want;
			radio_event <= #1 rf_want;
		end
	end
endmodule : event_source
`default_nettype wire

// ==== bench/sixteen_bit_capture_timer_bench.sv ====
`default_nettype none
module sixteen_bit_capture_timer_bench import capture_timer_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Stimulus and observed signals
	// ****************
	logic clk = 1'b0, nrst = 1'b0, clk_en = 1'b1;
	logic [2:0] tick_speed_select = '0, ts;
	logic [1:0] prescale_select = '0, count_mode_field = '0;
	logic [15:0] terminal_count_value = '0, seed = 16'h477A, c0, t;
	logic overflow_mask = 1'b0, timer_irq_enable = 1'b0;
	logic count_low_rd = 1'b0, count_low_wr = 1'b0, overflow_flag_clr = 1'b0;
	chan_cfg_s [NUM_CH-1:0] channel_control = '0;
	logic [RF_W-1:0] radio_event, radio_event_mask = '0, rf_want = '0;
	logic [NUM_CH-1:0] capture_pin, channel_flag_clr = '0, pin_want = '0;
	logic [NUM_CH-1:0] channel_flag, channel_dma_trigger;
	logic [7:0] count_low_byte, count_high_byte;
	logic overflow_flag, cpu_timer_flag, timer_irq;
	cnt_t [NUM_CH-1:0] channel_capture_value;
	int failures = 0, checks_done = 0;

	sixteen_bit_capture_timer i_dut (.clk, .nrst, .clk_en, .tick_speed_select,
		.prescale_select, .count_mode_field, .terminal_count_value, .overflow_mask,
		.timer_irq_enable, .channel_control, .radio_event, .radio_event_mask, .count_low_rd,
		.count_low_wr, .overflow_flag_clr, .channel_flag_clr, .capture_pin, .count_low_byte,
		.count_high_byte, .overflow_flag, .channel_flag, .cpu_timer_flag, .timer_irq,
		.channel_capture_value, .channel_dma_trigger);
	event_source i_src (.pin_want, .rf_want, .capture_pin, .radio_event);

	// 200 MHz clock
	initial begin
		forever #2.5 clk = ~clk;
	end

	// ****************
	// Helpers
	// ****************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done
	task automatic end_of_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	// Halt, clear count and overflow, then start in the given mode
	task automatic restart(input logic [1:0] m, input logic [2:0] ts, input logic [1:0] ps);
		count_mode_field = MODE_HALT;
		tick_speed_select = ts;
		prescale_select = ps;
		count_low_wr = 1'b1;
		overflow_flag_clr = 1'b1;
		cyc(1);
		count_low_wr = 1'b0;
		overflow_flag_clr = 1'b0;
		count_mode_field = m;
		cyc(1);
	endtask : restart
	task automatic clr_ch;
		channel_flag_clr = '1;
		cyc(1);
		channel_flag_clr = '0;
	endtask : clr_ch
	// Bounded wait; the flag is first seen with the count that set it
	task automatic wait_ovf(input int lim);
		for (int i = 0; i < lim && overflow_flag !== 1'b1; i++) cyc(1);
		check("overflow flag", overflow_flag, 1'b1);
	endtask : wait_ovf
	// Pin edge: two sync stages, so the stored count is two steps on
	task automatic pin_ev(input int ch, input logic lvl, input logic hit, input logic m);
		clr_ch();
		pin_want[ch] = lvl;
		c0 = 16'(count_low_byte) + 16'h0002;
		cyc(3);
		check("capture flag", channel_flag[ch], hit);
		check("dma pulse", channel_dma_trigger[ch], hit);
		check("cpu flag", cpu_timer_flag, hit & m);
		check("irq", timer_irq, hit & m);
		if (hit) check("capture value", channel_capture_value[ch], c0);
		cyc(1);
		check("dma end", channel_dma_trigger[ch], 1'b0);
	endtask : pin_ev
	// Radio strobes are not synchronised: captured at the next edge
	task automatic rf_ev(input logic [RF_W-1:0] ev, input logic hit);
		clr_ch();
		rf_want = ev;
		c0 = 16'(count_low_byte);
		cyc(1);
		rf_want = '0;
		check("radio flag", channel_flag[1], hit);
		if (hit) check("radio value", channel_capture_value[1], c0);
	endtask : rf_ev

	// Hang guard, well beyond the longest free-running wrap
	initial begin
		#450000;
		failures++;
		end_of_test();
	end

	// ****************
	// Scenarios
	// ****************
	initial begin
		cyc(16);
		nrst = 1'b1;
		cyc(10);
		check("count after reset", count_low_byte, 16'h0000);
		done("reset");
		// Exactly four steps in any window of four step periods
		for (int p = 0; p < 4; p++) begin
			seed = lfsr(seed);
			// Undivided pass may draw any tick select; divided ones stay short
			ts = (p == 0) ? seed[2:0] : 3'(seed % 3);
			restart(MODE_FREE, ts, 2'(p));
			c0 = 16'(count_low_byte);
			cyc(4 << ts << (p == 0 ? 0 : 2 * p + 1));
			check("steps", 16'(8'(count_low_byte - c0[7:0])), 16'h0004);
		end
		count_mode_field = MODE_HALT;
		cyc(1);
		c0 = 16'(count_low_byte);
		cyc(600);
		check("halted count", count_low_byte, c0);
		done("prescale and halt");
		restart(MODE_FREE, 3'h0, PRE_DIV1);
		cyc(20);
		count_low_wr = 1'b1;
		cyc(1);
		count_low_wr = 1'b0;
		check("cleared count", count_low_byte, 16'h0000);
		// Clock enable low freezes the running counter
		clk_en = 1'b0;
		cyc(8);
		check("frozen count", count_low_byte, 16'h0000);
		clk_en = 1'b1;
		cyc(16'h140);
		count_low_rd = 1'b1;
		cyc(1);
		count_low_rd = 1'b0;
		cyc(16'hFF);
		check("latched high", count_high_byte, 16'h0001);
		check("low after run", count_low_byte, 16'h0040);
		overflow_mask = 1'b1;
		wait_ovf(66000);
		check("overflow at top", count_low_byte, 16'h00FF);
		check("masked cpu flag", cpu_timer_flag, 1'b1);
		check("irq off", timer_irq, 1'b0);
		timer_irq_enable = 1'b1;
		cyc(1);
		check("wrap to zero", count_low_byte, 16'h0000);
		check("irq on", timer_irq, 1'b1);
		overflow_mask = 1'b0;
		cyc(1);
		check("flag kept", overflow_flag, 1'b1);
		check("mask drops cpu flag", cpu_timer_flag, 1'b0);
		done("free run");
		seed = lfsr(seed);
		t = 16'(seed % 40) + 16'h0005;
		terminal_count_value = t;
		restart(MODE_MOD, 3'h0, PRE_DIV1);
		wait_ovf(100);
		check("modulo top", count_low_byte, t);
		cyc(1);
		check("modulo wrap", count_low_byte, 16'h0000);
		restart(MODE_UPDN, 3'h0, PRE_DIV1);
		for (int i = 0; i < 100 && 16'(count_low_byte) !== t; i++) cyc(1);
		check("no flag at top", overflow_flag, 1'b0);
		cyc(1);
		check("turn down", count_low_byte, t - 16'h0001);
		wait_ovf(100);
		check("flag at zero", count_low_byte, 16'h0000);
		cyc(1);
		check("turn up", count_low_byte, 16'h0001);
		done("modulo and up/down");
		// Every edge code on every channel, mask drawn at random
		restart(MODE_FREE, 3'h0, PRE_DIV1);
		for (int ch = 0; ch < NUM_CH; ch++) begin
			for (int e = 0; e < 4; e++) begin
				seed = lfsr(seed);
				channel_control[ch] = '{2'(e), seed[0], 1'b0};
				pin_ev(ch, 1'b1, e[0], seed[0]);
				pin_ev(ch, 1'b0, e[1], seed[0]);
			end
			channel_control[ch] = '0;
		end
		// No capture while halted
		count_mode_field = MODE_HALT;
		channel_control[0] = '{EDGE_ANY, 1'b1, 1'b0};
		pin_ev(0, 1'b1, 1'b0, 1'b1);
		pin_ev(0, 1'b0, 1'b0, 1'b1);
		channel_control[0] = '0;
		done("pin capture");
		seed = lfsr(seed);
		restart(MODE_FREE, 3'h0, PRE_DIV1);
		radio_event_mask = 8'h01 << seed[2:0];
		channel_control[1] = '{EDGE_ANY, 1'b1, 1'b1};
		pin_ev(1, 1'b1, 1'b0, 1'b1);
		rf_ev(~radio_event_mask, 1'b0);
		rf_ev(radio_event_mask, 1'b1);
		pin_ev(1, 1'b0, 1'b0, 1'b1);
		done("radio capture");
		end_of_test();
	end
endmodule : sixteen_bit_capture_timer_bench
`default_nettype wire
